// [can_host_if.sv]
// cpu-side can controller: sfr ports, buffers, dma, sequencer
// Notes on behaviour
// - only four sfr ports plus dma reach controller
// - pointer selects register, data port carries it
// - command port reads flags, writes commands
// - status port reads status, writes dma pointer
// - dma copies receive buffer into main ram
// - transmission starts within 149 bit times
// - interface logic decodes commands, allocates buffers
// - ten byte transmit buffer filled by cpu
// - two ten byte receive buffers used alternately
// - reception continues while cpu holds other buffer
// - sequencer converts buffers to serial stream
// - bit timing follows edges seen on bus
// - driver logic sets output enable and level
// - error logic confines a faulty transmitter
// - protocol runs independently of cpu accesses
// - setup registers except test writable only under reset request
// - control segment at addresses 00h to 09h
// - reset request is control register bit 0
`timescale 1ns/100ps
`include "can_host_cfg.svh"
module can_host_if (
  input wire logic CLK, // system clock, 100 mhz
  input wire logic RESET_N, // asynchronous reset
  input wire can_host_pkg::sfr_req_type SFR_REQ, // cpu sfr access
  output logic [7:0] SFR_RDATA, // sfr read data
  input wire logic RAM_READY, // main ram takes a word
  output can_host_pkg::ram_word_type RAM_REQ, // dma word to main ram
  input wire logic CAN_RX, // bus receive pin
  output logic CAN_TX, // bus transmit level
  output logic CAN_TX_OE // bus driver enable
);

  can_host_pkg::state_type st_q;
  can_host_pkg::state_type st_d;

  // ****************************************
  // helper functions
  // ****************************************

  // total frame bits: start bit, descriptor, data
  function automatic logic [6:0] frame_len(input logic [3:0] dlc);
    logic [3:0] n;
    n = (dlc > `MAX_DLC) ? `MAX_DLC : dlc;
    frame_len = {n, 3'h0} + `HDR_BITS;
  endfunction : frame_len

  // level of the transmit bit at the current index
  function automatic logic tx_level(input can_host_pkg::state_type s);
    logic [6:0] k;
    k = s.bidx - 7'h01;
    if (s.bidx == 7'h00) begin
      tx_level = 1'b0;
    end else if (s.bidx < frame_len(s.txb[1][3:0])) begin
      tx_level = s.txb[k[6:3]][~k[2:0]];
    end else begin
      tx_level = 1'b1;
    end
  endfunction : tx_level

  // status byte built from live state
  function automatic logic [7:0] status_of(input can_host_pkg::state_type s);
    logic [7:0] r;
    r = 8'h00;
    r[`ST_RBS] = s.rx_full[s.rd_sel];
    r[`ST_DO] = s.ovr;
    r[`ST_TBS] = s.tbs;
    r[`ST_TCS] = s.tcs;
    r[`ST_RS] = (s.seq == can_host_pkg::SEQ_RX);
    r[`ST_TS] = (s.seq == can_host_pkg::SEQ_TX);
    r[`ST_ES] = (s.tec >= `ERR_WARN);
    r[`ST_BS] = s.busoff;
    status_of = r;
  endfunction : status_of

  // value seen through the data port at an internal address
  function automatic logic [7:0] reg_read(input can_host_pkg::state_type s, input logic [7:0] a);
    logic [7:0] ot;
    logic [7:0] orx;
    ot = a - `A_TXB;
    orx = a - `A_RXB;
    case (a)
      `A_CTRL: reg_read = s.ctrl;
      `A_CMD: reg_read = `UNMAPPED;
      `A_STAT: reg_read = status_of(s);
      `A_IRQ: reg_read = s.irq;
      `A_ACODE: reg_read = s.acode;
      `A_AMASK: reg_read = s.amask;
      `A_BT0: reg_read = s.bt0;
      `A_BT1: reg_read = s.bt1;
      `A_OC: reg_read = s.oc;
      `A_TEST: reg_read = s.test;
      default: begin
        if (a >= `A_TXB && a < `A_RXB) begin
          reg_read = s.txb[ot[3:0]];
        end else if (a >= `A_RXB && a < `A_END) begin
          reg_read = s.rxb[s.rd_sel][orx[3:0]];
        end else begin
          reg_read = `UNMAPPED;
        end
      end
    endcase
  endfunction : reg_read

  // command decode shared by both command paths
  function automatic can_host_pkg::state_type run_cmd(input can_host_pkg::state_type s, input logic [7:0] c);
    can_host_pkg::state_type r;
    r = s;
    if (c[`CMD_TR] && s.tbs && !s.ctrl[`CR_RR]) begin
      r.tr_pend = 1'b1;
      r.tbs = 1'b0;
      r.tcs = 1'b0;
    end
    if (c[`CMD_AT] && r.tr_pend && s.seq != can_host_pkg::SEQ_TX) begin
      r.tr_pend = 1'b0;
      r.tbs = 1'b1;
    end
    if (c[`CMD_RRB]) begin
      r.rx_full[s.rd_sel] = 1'b0;
      r.rd_sel = ~s.rd_sel;
    end
    if (c[`CMD_COS]) begin
      r.ovr = 1'b0;
    end
    run_cmd = r;
  endfunction : run_cmd

  // data port write into the controller address space
  function automatic can_host_pkg::state_type reg_write(input can_host_pkg::state_type s, input logic [7:0] d);
    can_host_pkg::state_type r;
    logic [7:0] ot;
    logic cfg_ok;
    r = s;
    ot = s.ptr - `A_TXB;
    cfg_ok = s.ctrl[`CR_RR];
    case (s.ptr)
      `A_CTRL: r.ctrl = d;
      `A_CMD: r = run_cmd(s, d);
      `A_ACODE: r.acode = cfg_ok ? d : s.acode;
      `A_AMASK: r.amask = cfg_ok ? d : s.amask;
      `A_BT0: r.bt0 = cfg_ok ? d : s.bt0;
      `A_BT1: r.bt1 = cfg_ok ? d : s.bt1;
      `A_OC: r.oc = cfg_ok ? d : s.oc;
      `A_TEST: r.test = d;
      default: begin
        if (s.ptr >= `A_TXB && s.ptr < `A_RXB && s.tbs) begin
          r.txb[ot[3:0]] = d;
        end
      end
    endcase
    reg_write = r;
  endfunction : reg_write

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic tq_en;
    logic samp;
    logic bend;
    logic fall;
    logic bitv;
    logic es_old;
    logic bus_idle;
    logic done;
    logic pop;
    logic push;
    logic w;
    logic [4:0] sp;
    logic [4:0] be;
    logic [6:0] k;
    can_host_pkg::ram_word_type p;
    st_d = st_q;
    tq_en = (st_q.div == st_q.bt0[5:0]);
    sp = {1'b0, st_q.bt1[3:0]} + 5'h01;
    be = sp + {2'h0, st_q.bt1[6:4]} + 5'h01;
    samp = tq_en && (st_q.seg == sp);
    bend = tq_en && (st_q.seg == be);
    bitv = st_q.sync2;
    fall = st_q.prev_rx & ~st_q.sync2;
    es_old = (st_q.tec >= `ERR_WARN);
    bus_idle = (st_q.idle_cnt == `IDLE_BITS);
    done = 1'b0;
    w = 1'b0;
    k = st_q.bidx - 7'h01;
    pop = st_q.head.v & RAM_READY;
    push = st_q.dma_busy & ~st_q.skid.v;
    p = '0;

    // bus pin synchroniser
    st_d.sync1 = CAN_RX;
    st_d.sync2 = st_q.sync1;
    st_d.prev_rx = st_q.sync2;

    // cpu sfr writes
    if (SFR_REQ.wr) begin
      case (SFR_REQ.sel)
        `SEL_PTR: st_d.ptr = SFR_REQ.wdata;
        `SEL_DATA: st_d = reg_write(st_q, SFR_REQ.wdata);
        `SEL_CMD: st_d = run_cmd(st_q, SFR_REQ.wdata);
        default: begin
          st_d.dma_ptr = SFR_REQ.wdata;
          st_d.dma_cnt = 4'h0;
          st_d.dma_busy = 1'b1;
        end
      endcase
    end

    // cpu sfr reads, flag register clears when read
    if (SFR_REQ.rd) begin
      case (SFR_REQ.sel)
        `SEL_PTR: st_d.rdata = st_q.ptr;
        `SEL_DATA: begin
          st_d.rdata = reg_read(st_q, st_q.ptr);
          if (st_q.ptr == `A_IRQ) begin
            st_d.irq = 8'h00;
          end
        end
        `SEL_CMD: begin
          st_d.rdata = st_q.irq;
          st_d.irq = 8'h00;
        end
        default: st_d.rdata = status_of(st_q);
      endcase
    end

    // bit timing: quantum divider, segment count, hard sync on edge
    st_d.div = tq_en ? 6'h00 : st_q.div + 6'h01;
    if (tq_en) begin
      st_d.seg = bend ? 5'h00 : st_q.seg + 5'h01;
    end
    if (fall && (st_q.seq == can_host_pkg::SEQ_IDLE || st_q.seg > sp)) begin
      st_d.div = 6'h00;
      st_d.seg = 5'h01;
    end

    // bit stream sequencer, runs on its own beside cpu traffic
    if (st_d.ctrl[`CR_RR]) begin
      st_d.seq = can_host_pkg::SEQ_IDLE;
      st_d.idle_cnt = 4'h0;
      st_d.tec = 9'h000;
      st_d.busoff = 1'b0;
      st_d.drv = 1'b1;
    end else if (samp) begin
      unique case (st_q.seq)
        can_host_pkg::SEQ_IDLE: begin
          if (!bitv && bus_idle) begin
            st_d.seq = can_host_pkg::SEQ_RX;
            st_d.bidx = 7'h01;
          end else if (!bitv) begin
            st_d.idle_cnt = 4'h0;
          end else if (!bus_idle) begin
            st_d.idle_cnt = st_q.idle_cnt + 4'h1;
          end
        end
        can_host_pkg::SEQ_RX, can_host_pkg::SEQ_TX: begin
          if (st_q.bidx != 7'h00) begin
            st_d.frm[k[6:3]][~k[2:0]] = bitv;
          end
          if (st_q.seq == can_host_pkg::SEQ_TX && bitv != st_q.drv) begin
            if (st_q.drv && st_q.bidx != 7'h00 && k < `ARB_BITS) begin
              st_d.seq = can_host_pkg::SEQ_RX; // lost arbitration
            end else begin
              st_d.tec = st_q.tec + `TEC_INC;
              st_d.seq = can_host_pkg::SEQ_IDLE;
              st_d.idle_cnt = 4'h0;
              st_d.drv = 1'b1;
            end
          end else if (st_q.bidx != 7'h00 && st_q.bidx == frame_len(st_d.frm[1][3:0]) - 7'h01) begin
            done = 1'b1;
          end else begin
            st_d.bidx = st_q.bidx + 7'h01;
          end
        end
        default: begin
          st_d.seq = can_host_pkg::SEQ_IDLE;
        end
      endcase
    end

    // frame end: transmit completion or receive store
    if (done) begin
      st_d.seq = can_host_pkg::SEQ_IDLE;
      st_d.idle_cnt = 4'h0;
      st_d.drv = 1'b1;
      if (st_q.seq == can_host_pkg::SEQ_TX) begin
        st_d.tcs = 1'b1;
        st_d.tbs = 1'b1;
        st_d.tr_pend = 1'b0;
        st_d.irq[`IR_TI] = 1'b1;
        if (st_d.tec != 9'h000) begin
          st_d.tec = st_d.tec - 9'h001;
        end
      end else if (((st_d.frm[0] ^ st_q.acode) & ~st_q.amask) == 8'h00) begin
        w = st_d.rx_full[st_d.rd_sel] ? ~st_d.rd_sel : st_d.rd_sel;
        if (st_d.rx_full[w]) begin
          st_d.ovr = 1'b1;
          st_d.irq[`IR_OI] = 1'b1;
        end else begin
          st_d.rxb[w] = st_d.frm;
          st_d.rx_full[w] = 1'b1;
          st_d.irq[`IR_RI] = 1'b1;
        end
      end
    end

    // error state changes and bus off
    if ((st_d.tec >= `ERR_WARN) != es_old) begin
      st_d.irq[`IR_EI] = 1'b1;
    end
    if (st_d.tec >= `ERR_OFF) begin
      st_d.busoff = 1'b1;
      st_d.seq = can_host_pkg::SEQ_IDLE;
      st_d.drv = 1'b1;
    end

    // bit boundary: start a pending frame or drive the next bit
    if (bend && !st_d.ctrl[`CR_RR]) begin
      if (st_d.seq == can_host_pkg::SEQ_TX) begin
        st_d.drv = tx_level(st_d);
      end else if (st_d.seq == can_host_pkg::SEQ_IDLE && bus_idle && st_d.tr_pend && !st_d.busoff) begin
        st_d.seq = can_host_pkg::SEQ_TX;
        st_d.bidx = 7'h00;
        st_d.drv = 1'b0;
      end else begin
        st_d.drv = 1'b1;
      end
    end

    // output driver level and enable
    st_d.out_tx = st_d.drv ^ st_d.oc[`OC_POL0];
    st_d.out_oe = ~(st_d.ctrl[`CR_RR] | st_d.ctrl[`CR_TM] | st_d.busoff | st_d.test[`TEST_FLOAT]);

    // two entry buffer towards main ram, back-pressure stalls dma
    if (pop) begin
      st_d.head = st_q.skid;
      st_d.skid.v = 1'b0;
    end
    if (push) begin
      p.v = 1'b1;
      p.a = st_q.dma_ptr + {4'h0, st_q.dma_cnt};
      p.d = st_q.rxb[st_q.rd_sel][st_q.dma_cnt];
      if (!st_d.head.v) begin
        st_d.head = p;
      end else begin
        st_d.skid = p;
      end
      if (!(SFR_REQ.wr && SFR_REQ.sel == `SEL_STA)) begin
        st_d.dma_cnt = st_q.dma_cnt + 4'h1;
        st_d.dma_busy = (st_q.dma_cnt != `DMA_LAST);
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q <= '0;
      st_q.ctrl <= `CTRL_RST;
      st_q.tbs <= 1'b1;
      st_q.drv <= 1'b1;
      st_q.out_tx <= 1'b1;
      st_q.sync1 <= 1'b1;
      st_q.sync2 <= 1'b1;
      st_q.prev_rx <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ports straight from the state register
  assign SFR_RDATA = st_q.rdata;
  assign RAM_REQ = st_q.head;
  assign CAN_TX = st_q.out_tx;
  assign CAN_TX_OE = st_q.out_oe;

endmodule : can_host_if

// [can_host_cfg.svh]
// constants for the cpu-side can controller interface
`ifndef CAN_HOST_CFG_SVH
`define CAN_HOST_CFG_SVH
// ****************************************
// sfr port selects
// ****************************************
`define SEL_PTR 2'h0
`define SEL_DATA 2'h1
`define SEL_CMD 2'h2
`define SEL_STA 2'h3
// ****************************************
// controller internal addresses
// ****************************************
`define A_CTRL 8'h00
`define A_CMD 8'h01
`define A_STAT 8'h02
`define A_IRQ 8'h03
`define A_ACODE 8'h04
`define A_AMASK 8'h05
`define A_BT0 8'h06
`define A_BT1 8'h07
`define A_OC 8'h08
`define A_TEST 8'h09
`define A_TXB 8'h0A
`define A_RXB 8'h14
`define A_END 8'h1E
`define UNMAPPED 8'hFF
// ****************************************
// field positions and reset values
// ****************************************
`define CR_RR 0
`define CR_TM 7
`define CTRL_RST 8'h01
`define CMD_TR 0
`define CMD_AT 1
`define CMD_RRB 2
`define CMD_COS 3
`define ST_RBS 0
`define ST_DO 1
`define ST_TBS 2
`define ST_TCS 3
`define ST_RS 4
`define ST_TS 5
`define ST_ES 6
`define ST_BS 7
`define IR_RI 0
`define IR_TI 1
`define IR_EI 2
`define IR_OI 3
`define OC_POL0 2
`define TEST_FLOAT 0
// ****************************************
// frame and error figures
// ****************************************
`define HDR_BITS 7'h11
`define ARB_BITS 7'h0C
`define MAX_DLC 4'h8
`define IDLE_BITS 4'hB
`define LATENCY_BITS 8'h95
`define ERR_WARN 9'h060
`define ERR_OFF 9'h100
`define TEC_INC 9'h008
`define DMA_LAST 4'h9
`endif

// [can_host_pkg.sv]
// types shared by the cpu-side can controller interface
package can_host_pkg;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_RX = 2'h1,
    SEQ_TX = 2'h2
  } seq_state_type;
  // ten byte message: descriptor pair then eight data bytes
  typedef logic [9:0][7:0] msg_type;
  // one cpu sfr access
  typedef struct packed {
    logic [1:0] sel;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_type;
  // one word on its way to main ram
  typedef struct packed {
    logic v;
    logic [7:0] a;
    logic [7:0] d;
  } ram_word_type;
  // ****************************************
  // complete block state
  // ****************************************
  typedef struct packed {
    logic [7:0] ptr, ctrl, irq, acode, amask, bt0, bt1, oc, test;
    msg_type txb;
    msg_type frm;
    msg_type [1:0] rxb;
    logic [1:0] rx_full;
    logic rd_sel, tbs, tcs, tr_pend, ovr, busoff;
    logic [8:0] tec;
    logic [7:0] rdata;
    logic sync1, sync2, prev_rx;
    logic [5:0] div;
    logic [4:0] seg;
    seq_state_type seq;
    logic [6:0] bidx;
    logic [3:0] idle_cnt;
    logic drv, out_tx, out_oe;
    logic [7:0] dma_ptr;
    logic [3:0] dma_cnt;
    logic dma_busy;
    ram_word_type head, skid;
  } state_type;
endpackage : can_host_pkg

// [can_host_sva.sv]
// assertion checker for the cpu-side can controller ports
`timescale 1ns/100ps
`include "can_host_cfg.svh"
module can_host_sva (
  input wire logic CLK, // clock
  input wire logic RESET_N, // async reset
  input wire can_host_pkg::sfr_req_type SFR_REQ, // sfr access
  input wire logic [7:0] SFR_RDATA, // read data
  input wire logic RAM_READY, // ram accepts
  input wire can_host_pkg::ram_word_type RAM_REQ, // dma word
  input wire logic CAN_RX, // bus in
  input wire logic CAN_TX, // bus out
  input wire logic CAN_TX_OE // driver enable
);
  logic [7:0] ptr_q;
  logic rr_q;
  logic drd;
  assign drd = SFR_REQ.rd && SFR_REQ.sel == `SEL_DATA;
  // follow pointer and reset request from cpu writes
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ptr_q <= 8'h00;
      rr_q <= 1'b1;
    end else begin
      if (SFR_REQ.wr && SFR_REQ.sel == `SEL_PTR) ptr_q <= SFR_REQ.wdata;
      if (SFR_REQ.wr && SFR_REQ.sel == `SEL_DATA && ptr_q == `A_CTRL) rr_q <= SFR_REQ.wdata[`CR_RR];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ****************************************
  // properties
  // ****************************************
  a_rdata_hold: assert property (!SFR_REQ.rd |=> $stable(SFR_RDATA)) else $error("read data moved");
  a_ptr_readback: assert property ((SFR_REQ.wr && !SFR_REQ.rd && SFR_REQ.sel == `SEL_PTR) ##1
    !(SFR_REQ.wr && SFR_REQ.sel == `SEL_PTR) ##1 (SFR_REQ.rd && !SFR_REQ.wr && SFR_REQ.sel == `SEL_PTR)
    |=> SFR_RDATA == $past(SFR_REQ.wdata, 3))
    else $error("pointer readback wrong");
  a_cmd_reads_ff: assert property (drd && ptr_q == `A_CMD |=> SFR_RDATA == 8'hFF) else $error("cmd read");
  a_unmapped_ff: assert property (drd && ptr_q >= `A_END |=> SFR_RDATA == 8'hFF) else $error("unmapped");
  a_dma_start: assert property (SFR_REQ.wr && SFR_REQ.sel == `SEL_STA |->
    ##2 RAM_REQ.v && RAM_REQ.a == $past(SFR_REQ.wdata, 2)) else $error("dma start wrong");
  a_ram_hold: assert property (RAM_REQ.v && !RAM_READY && !(SFR_REQ.wr && SFR_REQ.sel == `SEL_STA) |=>
    RAM_REQ.v && $stable(RAM_REQ.a) && $stable(RAM_REQ.d)) else $error("dma word dropped");
  a_ram_order: assert property (RAM_REQ.v && RAM_READY ##1 RAM_REQ.v |->
    RAM_REQ.a == $past(RAM_REQ.a) + 8'h01) else $error("dma address order");
  a_oe_reset_req: assert property (rr_q && $past(rr_q) |-> !CAN_TX_OE) else $error("driver on in reset");
endmodule : can_host_sva
bind can_host_if can_host_sva u_sva (.CLK(CLK), .RESET_N(RESET_N), .SFR_REQ(SFR_REQ), .SFR_RDATA(SFR_RDATA),
  .RAM_READY(RAM_READY), .RAM_REQ(RAM_REQ), .CAN_RX(CAN_RX), .CAN_TX(CAN_TX), .CAN_TX_OE(CAN_TX_OE));

// [ram_model.sv]
// main ram model that takes dma words promptly or with stalls
`timescale 1ns/100ps
module ram_model (
  input wire logic CLK, // clock
  input wire logic RESET_N, // async reset
  input wire can_host_pkg::ram_word_type RAM_REQ, // dma word
  input wire logic SLOW, // accept one cycle in four
  output logic RAM_READY // word taken at this edge
);
  logic [7:0] mem [0:255];
  logic [1:0] cnt_q;
  // stall pattern and store of accepted words
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if (RAM_REQ.v && RAM_READY) mem[RAM_REQ.a] <= RAM_REQ.d;
    end
  end
  assign RAM_READY = !SLOW || cnt_q == 2'h0;
endmodule : ram_model

// [testbench.sv]
// self-checking bench for the cpu-side can controller
`timescale 1ns/100ps
`include "can_host_cfg.svh"
module testbench;
  localparam int BIT_CLK = (1 + 1) * (1 + (2 + 1) + (1 + 1));
  logic clk;
  logic reset_n;
  logic rx_drv;
  logic slow;
  logic ram_ready;
  logic can_tx;
  logic can_tx_oe;
  logic [7:0] rdata;
  logic [7:0] cfg [0:5];
  can_host_pkg::sfr_req_type req;
  can_host_pkg::ram_word_type ram_req;
  int errors;
  int check_count;
  can_host_if dut (.CLK(clk), .RESET_N(reset_n), .SFR_REQ(req), .SFR_RDATA(rdata), .RAM_READY(ram_ready),
    .RAM_REQ(ram_req), .CAN_RX(rx_drv & (can_tx_oe ? can_tx : 1'b1)), .CAN_TX(can_tx), .CAN_TX_OE(can_tx_oe));
  ram_model ram (.CLK(clk), .RESET_N(reset_n), .RAM_REQ(ram_req), .SLOW(slow), .RAM_READY(ram_ready));
  // clock
  always #5 clk = ~clk;
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic sfr(input logic [1:0] sel, input logic wr, input logic [7:0] d);
    req.sel = sel;
    req.wr = wr;
    req.rd = !wr;
    req.wdata = d;
    @(posedge clk);
    #1;
    req = '0;
    @(posedge clk);
    #1;
  endtask : sfr
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    sfr(`SEL_PTR, 1'b1, a);
    sfr(`SEL_DATA, 1'b1, d);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    sfr(`SEL_PTR, 1'b1, a);
    sfr(`SEL_DATA, 1'b0, 8'h00);
    check(rdata, exp);
  endtask : reg_rd
  task automatic send_frame(input logic [7:0] id, input logic [7:0] dat);
    logic [24:0] bits;
    bits = {1'b0, id, 8'h01, dat}; // start bit, descriptor with one data byte
    for (int i = 24; i >= 0; i--) begin
      rx_drv = bits[i];
      repeat (BIT_CLK) @(posedge clk);
      #1;
    end
    rx_drv = 1'b1;
    repeat (12 * BIT_CLK) @(posedge clk);
    #1;
  endtask : send_frame
  task automatic dma(input logic [7:0] p);
    int n;
    n = 0;
    sfr(`SEL_STA, 1'b1, p);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ram_req.v === 1'b1 && n < 200);
  endtask : dma
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  // watchdog against a hang
  initial begin
    #300000;
    errors++;
    test_done;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    rx_drv = 1'b1;
    slow = 1'b0;
    req = '0;
    errors = 0;
    check_count = 0;
    cfg = '{8'hA5, 8'hFF, 8'h01, 8'h12, 8'h00, 8'h00};
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    // reset values and read-only places
    reg_rd(`A_CTRL, `CTRL_RST);
    reg_rd(`A_CMD, 8'hFF);
    reg_rd(`UNMAPPED, 8'hFF);
    sfr(`SEL_STA, 1'b0, 8'h00);
    check(rdata, 8'h04);
    sfr(`SEL_PTR, 1'b1, 8'h3C);
    sfr(`SEL_PTR, 1'b0, 8'h00);
    check(rdata, 8'h3C);
    $display("test reset done");
    // setup registers other than test only take writes under reset request
    for (int i = 0; i < 6; i++) reg_wr(`A_ACODE + 8'(i), cfg[i]);
    reg_wr(`A_CTRL, 8'h00);
    for (int i = 0; i < 5; i++) reg_wr(`A_ACODE + 8'(i), 8'hEE);
    for (int i = 0; i < 5; i++) reg_rd(`A_ACODE + 8'(i), cfg[i]);
    reg_rd(`A_CTRL, 8'h00);
    $display("test config lock done");
    // idle bits are only counted out of reset request, so let the bus go idle first
    repeat (12 * BIT_CLK) @(posedge clk);
    #1;
    // two frames land in alternate buffers
    send_frame(8'h31, 8'h5C);
    send_frame(8'h32, 8'hC3);
    sfr(`SEL_STA, 1'b0, 8'h00);
    check(rdata & 8'h01, 8'h01);
    sfr(`SEL_CMD, 1'b0, 8'h00);
    check(rdata & 8'h01, 8'h01);
    sfr(`SEL_CMD, 1'b0, 8'h00);
    check(rdata & 8'h01, 8'h00);
    reg_rd(`A_RXB, 8'h31);
    reg_rd(`A_RXB + 8'h02, 8'h5C);
    slow = 1'b1;
    dma(8'h40);
    check(ram.mem[8'h40], 8'h31);
    check(ram.mem[8'h41], 8'h01);
    check(ram.mem[8'h42], 8'h5C);
    sfr(`SEL_CMD, 1'b1, 8'h04);
    reg_rd(`A_RXB, 8'h32);
    reg_rd(`A_RXB + 8'h02, 8'hC3);
    slow = 1'b0;
    dma(8'h80);
    check(ram.mem[8'h82], 8'hC3);
    sfr(`SEL_CMD, 1'b1, 8'h04);
    sfr(`SEL_STA, 1'b0, 8'h00);
    check(rdata & 8'h01, 8'h00);
    $display("test receive done");
    // message out through the transmit buffer
    reg_wr(`A_TXB, 8'h55);
    reg_wr(`A_TXB + 8'h01, 8'h01);
    reg_wr(`A_TXB + 8'h02, 8'h9A);
    sfr(`SEL_CMD, 1'b1, 8'h01);
    sfr(`SEL_STA, 1'b0, 8'h00);
    check(rdata & 8'h04, 8'h00);
    for (int i = 0; i < 400 && rdata[`ST_TCS] !== 1'b1; i++) sfr(`SEL_STA, 1'b0, 8'h00);
    check(rdata & 8'h0C, 8'h0C);
    sfr(`SEL_CMD, 1'b0, 8'h00);
    check(rdata & 8'h02, 8'h02);
    $display("test transmit done");
    // driver enable and level follow float bit, reset request and polarity
    reg_wr(`A_TEST, 8'h01);
    check({7'h00, can_tx_oe}, 8'h00);
    reg_wr(`A_TEST, 8'h00);
    check({7'h00, can_tx_oe}, 8'h01);
    reg_wr(`A_CTRL, `CTRL_RST);
    reg_wr(`A_OC, 8'h04);
    check({7'h00, can_tx_oe}, 8'h00);
    check({7'h00, can_tx}, 8'h00);
    $display("test driver done");
    test_done;
  end
endmodule : testbench
